// ---- core/cts_arbiter.sv ----
// Fixed-priority pick of one request among simultaneous trap and interrupt requests.
`timescale 1ns/1ps
`default_nettype none
module cts_arbiter (
    input  wire logic [6:0] req,
    output logic      [6:0] grant,
    output logic            any
);
    // Lowest index wins; the isolation of the lowest set bit does the ordering.
    assign grant = req & ~(req - 7'h01);
    assign any   = |req;
endmodule : cts_arbiter
`default_nettype wire

// ---- core/cts_pkg.sv ----
// Shared constants and types of the trap-entry sequencer.
package cts_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [11:0] TBR_OFF     = 12'h000;
    localparam logic [11:0] SSP_OFF     = 12'h004;
    localparam logic [11:0] PSW_OFF     = 12'h008;
    localparam logic [11:0] COPRES_OFF  = 12'h00c;
    localparam logic [11:0] STATUS_OFF  = 12'h010;
    localparam logic [11:0] COUNT_OFF   = 12'h014;

    // Reset values.
    localparam logic [31:0] TBR_RST     = 32'h0000_0000;
    localparam logic [31:0] SSP_RST     = 32'h0000_0000;
    localparam logic [31:0] PSW_RST     = 32'h0000_0000;
    localparam logic [15:0] COPRES_RST  = 16'h0000;

    // Field positions inside the program status word.
    localparam int          PSW_I_BIT   = 4;
    localparam int          PSW_S_BIT   = 5;
    localparam int          PSW_T_BIT   = 8;
    localparam int          PSW_ILM_LSB = 16;
    localparam int          ILM_W       = 5;
    localparam logic [4:0]  ILM_DEBUG   = 5'h04;

    // Stack frame layout.
    localparam logic [31:0] PS_SLOT     = 32'h0000_0004;
    localparam logic [31:0] RA_SLOT     = 32'h0000_0008;
    localparam logic [31:0] STACK_DROP  = 32'h0000_0008;

    // Vector offsets from the table base.
    localparam logic [31:0] VEC_SWTRAP  = 32'h0000_03fc;
    localparam logic [31:0] VEC_DEBUG   = 32'h0000_03d8;
    localparam logic [31:0] VEC_STEP    = 32'h0000_03c4;
    localparam logic [31:0] VEC_COPROC  = 32'h0000_03e0;

    // Cycles from the trapping instruction to the first stack push.
    localparam int          TRAP_START_CYC = 6;

    // Request positions, index 0 is the highest priority.
    localparam int          SRC_UNDEF   = 0;
    localparam int          SRC_SWTRAP  = 1;
    localparam int          SRC_COPROC  = 2;
    localparam int          SRC_USER    = 3;
    localparam int          SRC_NMI     = 4;
    localparam int          SRC_STEP    = 5;
    localparam int          SRC_DEBUG   = 6;
    localparam int          NUM_SRC     = 7;

    // Codes of events handed to the interrupt and exception logic.
    localparam logic [1:0]  HAND_UNDEF  = 2'h0;
    localparam logic [1:0]  HAND_USER   = 2'h1;
    localparam logic [1:0]  HAND_NMI    = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_WAIT    = 5'h02,
        ST_PUSH_PS = 5'h04,
        ST_PUSH_RA = 5'h08,
        ST_COMMIT  = 5'h10
    } cts_state_t;

    typedef enum logic [2:0] {
        CAUSE_NONE   = 3'h0,
        CAUSE_SWTRAP = 3'h1,
        CAUSE_DEBUG  = 3'h2,
        CAUSE_STEP   = 3'h3,
        CAUSE_COPROC = 3'h4
    } cts_cause_t;

endpackage : cts_pkg

// ---- core/cts_trap_sequencer.sv ----
// Trap-entry sequencer: trap detection, priority, stack pushes, flag update and vectoring.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cts_trap_sequencer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        retire_valid,
    input  wire logic [31:0] retire_next_pc,
    input  wire logic        retire_is_swtrap,
    input  wire logic [7:0]  retire_swtrap_num,
    input  wire logic        retire_is_debug_trap,
    input  wire logic        retire_is_delayed_branch,
    input  wire logic        retire_is_coproc,
    input  wire logic [3:0]  retire_coproc_num,
    input  wire logic        retire_is_return_from_trap,
    input  wire logic        eit_undef_req,
    input  wire logic        eit_user_req,
    input  wire logic        eit_nmi_req,
    output logic             eit_handoff,
    output logic      [1:0]  eit_handoff_src,
    output logic             irq_accept_en,
    output logic             stall,
    output logic             flush,
    output logic             mem_wr_req,
    output logic      [31:0] mem_wr_addr,
    output logic      [31:0] mem_wr_data,
    input  wire logic        mem_wr_ack,
    output logic             pc_load,
    output logic      [31:0] pc_load_value,
    output logic      [31:0] program_status_word
);

    localparam logic [2:0] WAIT_LOAD = 3'(cts_pkg::TRAP_START_CYC - 2);

    cts_pkg::cts_state_t state_ff;
    cts_pkg::cts_state_t nxt_state;
    cts_pkg::cts_cause_t cause_ff;
    cts_pkg::cts_cause_t last_cause_ff;
    cts_pkg::cts_cause_t pick_cause;

    logic [31:0] table_base_reg_ff;
    logic [31:0] system_stack_pointer_ff;
    logic [31:0] psw_ff;
    logic [15:0] coproc_present_ff;
    logic [31:0] trap_count_ff;
    logic [31:0] ret_addr_ff;
    logic [31:0] saved_psw_ff;
    logic [7:0]  trap_num_ff;
    logic [2:0]  wait_cnt_ff;
    logic        in_handler_ff;
    logic        step_pend_ff;
    logic        slot_pend_ff;
    logic        flush_ff;
    logic        pc_load_ff;
    logic [31:0] pc_load_value_ff;
    logic [31:0] mem_wr_addr_ff;
    logic [31:0] mem_wr_data_ff;
    logic        handoff_ff;
    logic [1:0]  handoff_src_ff;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;

    logic        trace_on;
    logic        step_now;
    logic        dbg_req;
    logic        coproc_req;
    logic        boundary;
    logic [6:0]  req;
    logic [6:0]  grant;
    logic        grant_any;
    logic        take_trap;
    logic        take_step;
    logic        commit;
    logic [31:0] vector;
    logic        apb_setup;
    logic        apb_wr;

    // Register address decode, shared by the read and the write paths.
    function automatic logic [2:0] reg_index(input logic [11:0] addr);
        unique case (addr)
            cts_pkg::TBR_OFF:    reg_index = 3'h0;
            cts_pkg::SSP_OFF:    reg_index = 3'h1;
            cts_pkg::PSW_OFF:    reg_index = 3'h2;
            cts_pkg::COPRES_OFF: reg_index = 3'h3;
            cts_pkg::STATUS_OFF: reg_index = 3'h4;
            cts_pkg::COUNT_OFF:  reg_index = 3'h5;
            default:             reg_index = 3'h7;
        endcase
    endfunction : reg_index

    assign trace_on      = psw_ff[cts_pkg::PSW_T_BIT];
    assign irq_accept_en = ~trace_on;

    // Requests are judged only when an instruction retires with the sequencer idle,
    // so at most one entry sequence can be in flight.
    assign boundary   = retire_valid & (state_ff == cts_pkg::ST_IDLE);
    assign dbg_req    = retire_is_debug_trap & ~trace_on;
    assign coproc_req = retire_is_coproc & ~coproc_present_ff[retire_coproc_num];
    assign step_now   = trace_on & ~in_handler_ff
                        & (slot_pend_ff | ~retire_is_delayed_branch);

    always_comb
    begin
        req                        = 7'h00;
        req[cts_pkg::SRC_UNDEF]    = eit_undef_req;
        req[cts_pkg::SRC_SWTRAP]   = retire_is_swtrap;
        req[cts_pkg::SRC_COPROC]   = coproc_req;
        req[cts_pkg::SRC_USER]     = eit_user_req & ~trace_on;
        req[cts_pkg::SRC_NMI]      = eit_nmi_req & ~trace_on;
        req[cts_pkg::SRC_STEP]     = step_pend_ff | step_now;
        req[cts_pkg::SRC_DEBUG]    = dbg_req;
    end

    cts_arbiter u_arbiter (
        .req   (req),
        .grant (grant),
        .any   (grant_any)
    );

    always_comb
    begin
        pick_cause = cts_pkg::CAUSE_NONE;
        if (grant[cts_pkg::SRC_SWTRAP])
            pick_cause = cts_pkg::CAUSE_SWTRAP;
        else if (grant[cts_pkg::SRC_COPROC])
            pick_cause = cts_pkg::CAUSE_COPROC;
        else if (grant[cts_pkg::SRC_STEP])
            pick_cause = cts_pkg::CAUSE_STEP;
        else if (grant[cts_pkg::SRC_DEBUG])
            pick_cause = cts_pkg::CAUSE_DEBUG;
    end

    assign take_trap = boundary & grant_any & (pick_cause != cts_pkg::CAUSE_NONE);
    assign take_step = take_trap & (pick_cause == cts_pkg::CAUSE_STEP);
    assign commit    = (state_ff == cts_pkg::ST_COMMIT);

    cts_vector u_vector (
        .table_base (table_base_reg_ff),
        .cause      (cause_ff),
        .trap_num   (trap_num_ff),
        .vector     (vector)
    );

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            cts_pkg::ST_IDLE:
                if (take_trap)
                    nxt_state = cts_pkg::ST_WAIT;
            cts_pkg::ST_WAIT:
                if (wait_cnt_ff == 3'h0)
                    nxt_state = cts_pkg::ST_PUSH_PS;
            cts_pkg::ST_PUSH_PS:
                if (mem_wr_ack)
                    nxt_state = cts_pkg::ST_PUSH_RA;
            cts_pkg::ST_PUSH_RA:
                if (mem_wr_ack)
                    nxt_state = cts_pkg::ST_COMMIT;
            cts_pkg::ST_COMMIT:
                nxt_state = cts_pkg::ST_IDLE;
            default:
                nxt_state = cts_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= cts_pkg::ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wait_cnt_ff <= 3'h0;
        else if (take_trap)
            wait_cnt_ff <= WAIT_LOAD;
        else if (wait_cnt_ff != 3'h0)
            wait_cnt_ff <= wait_cnt_ff - 3'h1;
    end

    // The cause, return address and trap number are captured at the boundary, because the
    // pipeline moves on to other instructions while the wait runs.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cause_ff    <= cts_pkg::CAUSE_NONE;
            ret_addr_ff <= 32'h0000_0000;
            trap_num_ff <= 8'h00;
        end
        else if (take_trap)
        begin
            cause_ff    <= pick_cause;
            ret_addr_ff <= retire_next_pc;
            trap_num_ff <= retire_swtrap_num;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flush_ff <= 1'b0;
        else
            flush_ff <= take_trap;
    end

    // A step request that loses to a higher source is kept until it wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            step_pend_ff <= 1'b0;
        else if (boundary)
            step_pend_ff <= (step_now | step_pend_ff) & ~take_step;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            slot_pend_ff <= 1'b0;
        else if (retire_valid)
            slot_pend_ff <= trace_on & ~in_handler_ff & retire_is_delayed_branch;
    end

    // Handler entry wins over a return seen in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            in_handler_ff <= 1'b0;
        else if (commit & ((cause_ff == cts_pkg::CAUSE_STEP) | (cause_ff == cts_pkg::CAUSE_DEBUG)))
            in_handler_ff <= 1'b1;
        else if (retire_valid & retire_is_return_from_trap)
            in_handler_ff <= 1'b0;
    end

    // Sources that this block does not sequence are passed on when they win.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            handoff_ff     <= 1'b0;
            handoff_src_ff <= cts_pkg::HAND_UNDEF;
        end
        else
        begin
            handoff_ff <= boundary & grant_any & (pick_cause == cts_pkg::CAUSE_NONE);
            if (grant[cts_pkg::SRC_USER])
                handoff_src_ff <= cts_pkg::HAND_USER;
            else if (grant[cts_pkg::SRC_NMI])
                handoff_src_ff <= cts_pkg::HAND_NMI;
            else
                handoff_src_ff <= cts_pkg::HAND_UNDEF;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_wr_addr_ff <= 32'h0000_0000;
            mem_wr_data_ff <= 32'h0000_0000;
            saved_psw_ff   <= 32'h0000_0000;
        end
        else if ((state_ff == cts_pkg::ST_WAIT) && (wait_cnt_ff == 3'h0))
        begin
            mem_wr_addr_ff <= system_stack_pointer_ff - cts_pkg::PS_SLOT;
            mem_wr_data_ff <= psw_ff;
            saved_psw_ff   <= psw_ff;
        end
        else if ((state_ff == cts_pkg::ST_PUSH_PS) && mem_wr_ack)
        begin
            mem_wr_addr_ff <= system_stack_pointer_ff - cts_pkg::RA_SLOT;
            mem_wr_data_ff <= ret_addr_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_load_ff       <= 1'b0;
            pc_load_value_ff <= 32'h0000_0000;
        end
        else
        begin
            pc_load_ff <= commit;
            if (commit)
                pc_load_value_ff <= vector;
        end
    end

    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pwrite & (reg_index(paddr) != 3'h7);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            table_base_reg_ff <= cts_pkg::TBR_RST;
        else if (apb_wr && reg_index(paddr) == 3'h0)
            table_base_reg_ff <= pwdata;
    end

    // The stack pointer drops only after both pushes are acknowledged.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            system_stack_pointer_ff <= cts_pkg::SSP_RST;
        else if (commit)
            system_stack_pointer_ff <= system_stack_pointer_ff - cts_pkg::STACK_DROP;
        else if (apb_wr && reg_index(paddr) == 3'h1)
            system_stack_pointer_ff <= pwdata;
    end

    // The flag update at entry wins over a software write in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            psw_ff <= cts_pkg::PSW_RST;
        else if (commit)
        begin
            psw_ff[cts_pkg::PSW_S_BIT] <= 1'b0;
            if (cause_ff == cts_pkg::CAUSE_SWTRAP)
                psw_ff[cts_pkg::PSW_I_BIT] <= 1'b0;
            if (cause_ff == cts_pkg::CAUSE_DEBUG)
                psw_ff[cts_pkg::PSW_ILM_LSB +: cts_pkg::ILM_W] <= cts_pkg::ILM_DEBUG;
        end
        else if (apb_wr && reg_index(paddr) == 3'h2)
            psw_ff <= pwdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            coproc_present_ff <= cts_pkg::COPRES_RST;
        else if (apb_wr && reg_index(paddr) == 3'h3)
            coproc_present_ff <= pwdata[15:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_cause_ff <= cts_pkg::CAUSE_NONE;
        else if (commit)
            last_cause_ff <= cause_ff;
    end

    // Writing the count register clears it; an entry in that cycle still counts.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trap_count_ff <= 32'h0000_0000;
        else if (commit)
            trap_count_ff <= (apb_wr && reg_index(paddr) == 3'h5) ? 32'h0000_0001
                                                                  : trap_count_ff + 32'h0000_0001;
        else if (apb_wr && reg_index(paddr) == 3'h5)
            trap_count_ff <= 32'h0000_0000;
    end

    // Read data is captured in the setup phase so the slave answers with no wait.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else if (apb_setup)
        begin
            pslverr_ff <= (reg_index(paddr) == 3'h7);
            unique case (reg_index(paddr))
                3'h0:    prdata_ff <= table_base_reg_ff;
                3'h1:    prdata_ff <= system_stack_pointer_ff;
                3'h2:    prdata_ff <= psw_ff;
                3'h3:    prdata_ff <= {16'h0000, coproc_present_ff};
                3'h4:    prdata_ff <= {16'h0000, 5'h00, last_cause_ff,
                                       in_handler_ff, step_pend_ff, slot_pend_ff, state_ff};
                3'h5:    prdata_ff <= trap_count_ff;
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata              = prdata_ff;
    assign pready              = 1'b1;
    assign pslverr             = pslverr_ff & psel & penable;
    assign stall               = (state_ff != cts_pkg::ST_IDLE);
    assign flush               = flush_ff;
    assign mem_wr_req          = (state_ff == cts_pkg::ST_PUSH_PS) | (state_ff == cts_pkg::ST_PUSH_RA);
    assign mem_wr_addr         = mem_wr_addr_ff;
    assign mem_wr_data         = mem_wr_data_ff;
    assign pc_load             = pc_load_ff;
    assign pc_load_value       = pc_load_value_ff;
    assign eit_handoff         = handoff_ff;
    assign eit_handoff_src     = handoff_src_ff;
    assign program_status_word = psw_ff;

endmodule : cts_trap_sequencer
`default_nettype wire

// ---- core/cts_vector.sv ----
// Handler address lookup for each trap cause.
`timescale 1ns/1ps
`default_nettype none
module cts_vector (
    input  wire logic [31:0]        table_base,
    input  wire cts_pkg::cts_cause_t cause,
    input  wire logic [7:0]         trap_num,
    output logic      [31:0]        vector
);
    logic [31:0] offset;

    always_comb
    begin
        unique case (cause)
            cts_pkg::CAUSE_SWTRAP: offset = cts_pkg::VEC_SWTRAP - {22'h0, trap_num, 2'b00};
            cts_pkg::CAUSE_DEBUG:  offset = cts_pkg::VEC_DEBUG;
            cts_pkg::CAUSE_STEP:   offset = cts_pkg::VEC_STEP;
            cts_pkg::CAUSE_COPROC: offset = cts_pkg::VEC_COPROC;
            default:               offset = 32'h0000_0000;
        endcase
    end

    assign vector = table_base + offset;
endmodule : cts_vector
`default_nettype wire

// ---- verif/cts_mem_model.sv ----
// Stack memory stand-in that takes pushes at once or after two wait cycles.
`timescale 1ns/1ps
`default_nettype none
module cts_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        slow,
    input  wire logic        mem_wr_req,
    input  wire logic [31:0] mem_wr_addr,
    input  wire logic [31:0] mem_wr_data,
    output logic             mem_wr_ack
);
    logic [1:0]  wait_ff;
    logic        n_ff;
    logic [31:0] a_ff [2];
    logic [31:0] d_ff [2];
    // Acknowledge only while a push is requested, so a late answer never leaks.
    assign mem_wr_ack = mem_wr_req && (!slow || wait_ff == 2'h2);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_ff <= 2'h0;
            n_ff    <= 1'b0;
        end
        else if (mem_wr_ack)
        begin
            wait_ff     <= 2'h0;
            n_ff        <= ~n_ff;
            a_ff[n_ff]  <= mem_wr_addr;
            d_ff[n_ff]  <= mem_wr_data;
        end
        else if (mem_wr_req)
            wait_ff <= wait_ff + 2'h1;
    end
endmodule : cts_mem_model
`default_nettype wire

// ---- verif/cts_trap_sequencer_sva.sv ----
// Port-level assertions of the trap sequencer.
`timescale 1ns/1ps
`default_nettype none
module cts_trap_sequencer_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        retire_valid,
    input wire logic        retire_is_swtrap,
    input wire logic        eit_undef_req,
    input wire logic        stall,
    input wire logic        flush,
    input wire logic        mem_wr_req,
    input wire logic        mem_wr_ack,
    input wire logic [31:0] mem_wr_addr,
    input wire logic [31:0] mem_wr_data,
    input wire logic        pc_load,
    input wire logic        irq_accept_en,
    input wire logic        eit_handoff,
    input wire logic [1:0]  eit_handoff_src,
    input wire logic [31:0] program_status_word
);
    logic first_ff;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            first_ff <= 1'b0;
        else if (flush)
            first_ff <= 1'b1;
        else if (mem_wr_req && mem_wr_ack)
            first_ff <= 1'b0;
    end
    sequence s_sw_win;
        retire_valid && !stall && retire_is_swtrap && !eit_undef_req;
    endsequence
    a_sw_latency: assert property (s_sw_win |-> ##6 $rose(mem_wr_req))
        else $error("software trap push late or early");
    a_flush_next: assert property (s_sw_win |=> flush && stall)
        else $error("no flush after accepted trap");
    a_push_first: assert property ($rose(mem_wr_req) |->
        $past(flush, 5) && mem_wr_data == program_status_word)
        else $error("first push is not the status word");
    a_req_hold: assert property (mem_wr_req && !mem_wr_ack |=>
        mem_wr_req && $stable(mem_wr_addr) && $stable(mem_wr_data))
        else $error("push request changed before ack");
    a_second_push: assert property (mem_wr_req && mem_wr_ack && first_ff |=>
        mem_wr_req && mem_wr_addr == $past(mem_wr_addr) - 32'h4)
        else $error("second push not one word below the first");
    a_trace_mask: assert property (irq_accept_en == !program_status_word[8])
        else $error("interrupt accept does not follow trace flag");
    a_undef_wins: assert property (retire_valid && !stall && eit_undef_req |=>
        eit_handoff && eit_handoff_src == 2'h0 && !flush)
        else $error("undefined request did not win");
    a_pc_pulse: assert property (pc_load |-> !stall && $past(stall) ##1 !pc_load)
        else $error("handler load not a single closing pulse");
    a_stall_hold: assert property ($rose(stall) |-> stall [*6])
        else $error("stall dropped during entry wait");
endmodule : cts_trap_sequencer_sva
bind cts_trap_sequencer cts_trap_sequencer_sva u_sva (.pclk, .presetn, .retire_valid,
    .retire_is_swtrap, .eit_undef_req, .stall, .flush, .mem_wr_req, .mem_wr_ack, .mem_wr_addr,
    .mem_wr_data, .pc_load, .irq_accept_en, .eit_handoff, .eit_handoff_src,
    .program_status_word);
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench of the trap sequencer with a stack memory model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        slow = 1'b0, retire_valid = 1'b0, retire_is_swtrap = 1'b0;
    logic        retire_is_debug_trap = 1'b0, retire_is_delayed_branch = 1'b0;
    logic        retire_is_coproc = 1'b0, retire_is_return_from_trap = 1'b0;
    logic        eit_undef_req = 1'b0, eit_user_req = 1'b0, eit_nmi_req = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, retire_next_pc = 32'h0, rd;
    logic [7:0]  retire_swtrap_num = 8'h00;
    logic [3:0]  retire_coproc_num = 4'h0;
    logic        pready, pslverr, eit_handoff, irq_accept_en, stall, flush, err;
    logic        mem_wr_req, mem_wr_ack, pc_load;
    logic [1:0]  eit_handoff_src;
    logic [31:0] prdata, mem_wr_addr, mem_wr_data, pc_load_value, program_status_word;
    int          n_mismatch = 0, n_tests = 0, cyc = 0;
    cts_trap_sequencer uut (.*);
    cts_mem_model mem (.*);
    always #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task ret(input logic [4:0] k, input logic [7:0] n, input logic [31:0] pc);
        @(posedge pclk);
        while (stall !== 1'b0) @(posedge pclk);
        retire_valid <= 1'b1;
        {retire_is_return_from_trap, retire_is_coproc, retire_is_delayed_branch,
            retire_is_debug_trap, retire_is_swtrap} <= k;
        retire_swtrap_num <= n;
        retire_coproc_num <= n[3:0];
        retire_next_pc <= pc;
        @(posedge pclk);
        retire_valid <= 1'b0;
        {retire_is_return_from_trap, retire_is_coproc, retire_is_delayed_branch,
            retire_is_debug_trap, retire_is_swtrap} <= 5'h00;
    endtask : ret
    task quiet(input string what);
        logic s;
        s = 1'b0;
        repeat (10) @(posedge pclk) s |= flush;
        cmp(what, 32'h0, {31'h0, s});
    endtask : quiet
    task trap(input logic [4:0] k, input logic [7:0] n, input logic [31:0] pc, psw, vec, po);
        int i;
        apb(1'b1, cts_pkg::SSP_OFF, 32'h2000);
        apb(1'b1, cts_pkg::PSW_OFF, psw);
        ret(k, n, pc);
        i = 0;
        do @(posedge pclk); while (pc_load !== 1'b1 && i++ < 40);
        cmp("vector", vec, pc_load_value);
        cmp("status slot", 32'h1ffc, mem.a_ff[0]);
        cmp("status pushed", psw, mem.d_ff[0]);
        cmp("return slot", 32'h1ff8, mem.a_ff[1]);
        cmp("return pushed", pc, mem.d_ff[1]);
        apb(1'b0, cts_pkg::SSP_OFF, 32'h0);
        cmp("stack pointer", 32'h1ff8, rd);
        apb(1'b0, cts_pkg::PSW_OFF, 32'h0);
        cmp("new status", po, rd);
    endtask : trap
    task leave;
        apb(1'b1, cts_pkg::PSW_OFF, 32'h0);
        ret(5'h10, 8'h00, 32'h0);
    endtask : leave
    task t_sw;
        trap(5'h01, 8'h03, 32'h100, 32'h30, 32'h13f0, 32'h0);
        slow <= 1'b1;
        trap(5'h01, 8'hff, 32'h104, 32'h0003_0010, 32'h1000, 32'h0003_0000);
        $display("software trap test done");
    endtask : t_sw
    task t_dbg;
        trap(5'h02, 8'h00, 32'h200, 32'h0001_0030, 32'h13d8, 32'h0004_0010);
        leave();
        $display("debug trap test done");
    endtask : t_dbg
    task t_cop;
        apb(1'b1, cts_pkg::COPRES_OFF, 32'h21);
        ret(5'h08, 8'h05, 32'h300);
        quiet("present unit");
        trap(5'h08, 8'h07, 32'h304, 32'h30, 32'h13e0, 32'h10);
        slow <= 1'b0;
        $display("coprocessor test done");
    endtask : t_cop
    task t_step;
        apb(1'b1, cts_pkg::PSW_OFF, 32'h120);
        ret(5'h04, 8'h00, 32'h400);
        quiet("after branch");
        trap(5'h00, 8'h00, 32'h404, 32'h120, 32'h13c4, 32'h100);
        cmp("interrupt accept", 32'h0, {31'h0, irq_accept_en});
        ret(5'h00, 8'h00, 32'h408);
        quiet("inside handler");
        leave();
        trap(5'h02, 8'h00, 32'h500, 32'h120, 32'h13c4, 32'h100);
        leave();
        $display("step trace test done");
    endtask : t_step
    task t_prio;
        for (int i = 0; i < 3; i++)
        begin
            {eit_nmi_req, eit_user_req, eit_undef_req} <= 3'h1 << i;
            ret((i == 0) ? 5'h01 : 5'h00, 8'h00, 32'h600);
            @(posedge pclk);
            cmp("handoff", 32'h1, {31'h0, eit_handoff});
            cmp("handoff source", i, {30'h0, eit_handoff_src});
            {eit_nmi_req, eit_user_req, eit_undef_req} <= 3'h0;
            quiet("after handoff");
        end
        eit_user_req <= 1'b1;
        trap(5'h01, 8'h00, 32'h604, 32'h20, 32'h13fc, 32'h0);
        eit_user_req <= 1'b0;
        $display("priority test done");
    endtask : t_prio
    task t_regs(input logic [31:0] n, st);
        apb(1'b0, cts_pkg::COUNT_OFF, 32'h0);
        cmp("entry count", n, rd);
        apb(1'b0, cts_pkg::STATUS_OFF, 32'h0);
        cmp("status", st, rd);
        apb(1'b0, 12'h020, 32'h0);
        cmp("unmapped error", 32'h1, {31'h0, err});
        cmp("unmapped data", 32'h0, rd);
        $display("register test done");
    endtask : t_regs
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs(32'h0, 32'h1);
        apb(1'b1, cts_pkg::TBR_OFF, 32'h1000);
        t_sw();
        t_dbg();
        t_cop();
        t_step();
        t_prio();
        t_regs(32'h7, 32'h101);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
